// ### verilog/pctl_cfg.svh
// Purpose: constants for the processor control and move-register decoder
// Assumes: big-endian instruction bit numbers mapped to [31:0], bit 0 = MSB
// Notes:   offsets, register numbers, reset values and timing counts
`ifndef PCTL_CFG_SVH
`define PCTL_CFG_SVH

////////////////////////////////////////////////////////////////////////////
// Primary and extended opcodes
`define OPC_SYSCALL      6'h11
`define OPC_EXTENDED     6'h1F
`define XO_MTCRF         10'h090
`define XO_MCRXR         10'h200
`define XO_MFCR          10'h013
`define XO_MTSPR         10'h1D3
`define XO_MFSPR         10'h153
`define XO_MFTB          10'h173
`define XO_MFMSR         10'h053
`define XO_MTMSR         10'h092

////////////////////////////////////////////////////////////////////////////
// Exception vector offsets
`define VEC_SYSCALL      32'h0000_0C00
`define VEC_PROGRAM      32'h0000_0700

////////////////////////////////////////////////////////////////////////////
// Special-purpose register numbers (10-bit, after half swap)
`define SPR_FXER         10'h001
`define SPR_LINK         10'h008
`define SPR_COUNT        10'h009
`define SPR_TB_RD_LO     10'h10C
`define SPR_TB_RD_HI     10'h10D
`define SPR_TB_WR_LO     10'h11C
`define SPR_TB_WR_HI     10'h11D
`define SPR_VERSION      10'h11F
`define SPR_UPERF_FIRST  10'h3A8
`define SPR_UPERF_LAST   10'h3AE
`define SPR_HWCFG_A      10'h3F0
`define SPR_HWCFG_B      10'h3F1
`define SPR_L2CTRL       10'h3F9
// Supervisor read/write numbers: ranges as first and last, plus single numbers
`define SPR_SV_A_FIRST   10'h012
`define SPR_SV_A_LAST    10'h013
`define SPR_SV_DEC       10'h016
`define SPR_SV_B_FIRST   10'h019
`define SPR_SV_B_LAST    10'h01B
`define SPR_SV_C_FIRST   10'h110
`define SPR_SV_C_LAST    10'h113
`define SPR_SV_EXTADDR   10'h11A
`define SPR_SV_D_FIRST   10'h210
`define SPR_SV_D_LAST    10'h21F
`define SPR_SV_E_FIRST   10'h3B8
`define SPR_SV_E_LAST    10'h3BE
`define SPR_SV_F_FIRST   10'h3F2
`define SPR_SV_DBREAK    10'h3F5
`define SPR_SV_G_FIRST   10'h3FB
`define SPR_SV_G_LAST    10'h3FE

////////////////////////////////////////////////////////////////////////////
// Reset values
`define CR_RESET         32'h0000_0000
`define FXER_RESET       32'h0000_0000
`define LINK_RESET       32'h0000_0000
`define COUNT_RESET      32'h0000_0000
`define MSR_RESET        32'h0000_0000
`define TB_RESET         64'h0000_0000_0000_0000

////////////////////////////////////////////////////////////////////////////
// Timing: time base tick period and the clock
`define CLK_PERIOD_NS    20
`define TB_PERIOD_NS     80
`define TB_DIV           (`TB_PERIOD_NS / `CLK_PERIOD_NS)
`define TB_DIV_W         4

`endif

// ### verilog/pctl_pkg.sv
// Purpose: types shared by the processor control decoder and its users
// Assumes: nothing beyond standard SystemVerilog
// Notes:   constants live in pctl_cfg.svh
`default_nettype none
package pctl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Decoded operation
    typedef enum logic [3:0] {
        OP_NONE, OP_SYSCALL, OP_MTCRF, OP_MCRXR, OP_MFCR,
        OP_MTSPR, OP_MFSPR, OP_MFTB, OP_MFMSR, OP_MTMSR, OP_ILLEGAL
    } op_e;

    // Sequencer state
    typedef enum logic [0:0] {ST_IDLE, ST_EXT_READ} state_e;

    // Exception cause
    typedef enum logic [1:0] {
        EXC_NONE, EXC_SYSCALL, EXC_PRIVILEGED, EXC_ILLEGAL
    } exc_cause_e;

    ////////////////////////////////////////////////////////////////////////
    // Access class of one register number
    typedef struct packed {
        logic known;
        logic rd_user;
        logic wr_user;
        logic rd_sup;
        logic wr_sup;
    } spr_access_s;

    // General register write-back
    typedef struct packed {
        logic        we;
        logic [4:0]  addr;
        logic [31:0] data;
    } gpr_wr_s;

    // Request to an outside special-purpose register
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [9:0]  num;
        logic [31:0] wdata;
    } spr_req_s;

    // Exception report
    typedef struct packed {
        logic        valid;
        exc_cause_e  cause;
        logic [31:0] vector;
    } exc_s;

endpackage
`default_nettype wire

// ### verilog/cr_field_merge.sv
// Purpose: merge one 4-bit condition register field under a select bit
// Assumes: purely combinational, used once per field
// Notes:   identical path for any select, so the latency never varies
`timescale 1ns/1ps
`default_nettype none
module cr_field_merge (
    // Field values
    input  wire logic [3:0] old_field,
    input  wire logic [3:0] new_field,
    // Select
    input  wire logic       sel,
    // Result
    output logic      [3:0] merged
);
    // Take new nibble when selected
    assign merged = sel ? new_field : old_field;
endmodule
`default_nettype wire

// ### verilog/pctl_decoder.sv
// Purpose: decode and execute system call, condition register moves and
//          special-purpose register moves
// Assumes: INSTR arrives with its source general register value in RS_DATA
// Notes:   outside registers are read through SPR_REQ and SPR_RDATA
`timescale 1ns/1ps
`default_nettype none
`include "pctl_cfg.svh"
module pctl_decoder (
    // Clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              RST_N,
    // Instruction in
    input  wire logic              INSTR_VALID,
    input  wire logic [31:0]       INSTR,
    input  wire logic [31:0]       RS_DATA,
    input  wire logic              SUPERVISOR,
    output logic                   READY,
    // Outside registers
    output pctl_pkg::spr_req_s     SPR_REQ,
    input  wire logic [31:0]       SPR_RDATA,
    // Results
    output pctl_pkg::gpr_wr_s      GPR_WR,
    output pctl_pkg::exc_s         EXC,
    output logic [31:0]            CR_VALUE,
    output logic [31:0]            MSR_VALUE
);
    import pctl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Access class of a register number
    function automatic spr_access_s classify(input logic [9:0] n);
        spr_access_s a;
        a = '0;
        if (n == `SPR_FXER || n == `SPR_LINK || n == `SPR_COUNT) begin
            a = 5'b1_1111;
        end else if (n == `SPR_TB_RD_LO || n == `SPR_TB_RD_HI) begin
            a = 5'b1_1010;
        end else if (n == `SPR_TB_WR_LO || n == `SPR_TB_WR_HI) begin
            a = 5'b1_0001;
        end else if (n >= `SPR_UPERF_FIRST && n <= `SPR_UPERF_LAST) begin
            a = 5'b1_1010;
        end else if (n == `SPR_VERSION) begin
            a = 5'b1_0010;
        end else if (n == `SPR_HWCFG_A || n == `SPR_HWCFG_B
                     || n == `SPR_L2CTRL) begin
            a = 5'b1_0011;
        end else if ((n >= `SPR_SV_A_FIRST && n <= `SPR_SV_A_LAST)
                     || n == `SPR_SV_DEC || n == `SPR_SV_EXTADDR
                     || (n >= `SPR_SV_B_FIRST && n <= `SPR_SV_B_LAST)
                     || (n >= `SPR_SV_C_FIRST && n <= `SPR_SV_C_LAST)
                     || (n >= `SPR_SV_D_FIRST && n <= `SPR_SV_D_LAST)
                     || (n >= `SPR_SV_E_FIRST && n <= `SPR_SV_E_LAST)
                     || n == `SPR_SV_F_FIRST || n == `SPR_SV_DBREAK
                     || (n >= `SPR_SV_G_FIRST && n <= `SPR_SV_G_LAST)) begin
            a = 5'b1_0011;
        end
        return a;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    state_e      state;
    logic [31:0] cr;
    logic [31:0] fxer;
    logic [31:0] link;
    logic [31:0] count;
    logic [31:0] machine_state_register;
    logic [63:0] tb;
    logic [`TB_DIV_W-1:0] tb_div;
    logic [4:0]  pend_rd;
    logic        ready;
    spr_req_s    spr_req;
    gpr_wr_s     gpr_wr;
    exc_s        exc;

    state_e      next_state;
    logic [31:0] next_cr;
    logic [31:0] next_fxer;
    logic [31:0] next_link;
    logic [31:0] next_count;
    logic [31:0] next_msr;
    logic [63:0] next_tb;
    logic [`TB_DIV_W-1:0] next_tb_div;
    logic [4:0]  next_pend_rd;
    logic        next_ready;
    spr_req_s    next_spr_req;
    gpr_wr_s     next_gpr_wr;
    exc_s        next_exc;

    ////////////////////////////////////////////////////////////////////////
    // Field extraction
    op_e         op;
    logic [9:0]  spr_num;
    logic [4:0]  rd_rs;
    logic [2:0]  crf;
    logic [7:0]  field_select_mask;
    logic [31:0] crm_merged;
    spr_access_s acc;
    logic        take;

    assign spr_num = {INSTR[15:11], INSTR[20:16]};
    assign rd_rs   = INSTR[25:21];
    assign crf     = INSTR[25:23];
    assign field_select_mask     = INSTR[19:12];
    assign acc     = classify(spr_num);
    assign take    = INSTR_VALID && ready;

    // Opcode decode
    always_comb begin
        op = OP_ILLEGAL;
        if (INSTR[31:26] == `OPC_SYSCALL && INSTR[1]) begin
            op = OP_SYSCALL;
        end else if (INSTR[31:26] == `OPC_EXTENDED) begin
            unique case (INSTR[10:1])
                `XO_MTCRF: op = OP_MTCRF;
                `XO_MCRXR: op = OP_MCRXR;
                `XO_MFCR:  op = OP_MFCR;
                `XO_MTSPR: op = OP_MTSPR;
                `XO_MFSPR: op = OP_MFSPR;
                `XO_MFTB:  op = OP_MFTB;
                `XO_MFMSR: op = OP_MFMSR;
                `XO_MTMSR: op = OP_MTMSR;
                default:   op = OP_ILLEGAL;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-field merge for the masked condition register move
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_field
            cr_field_merge u_merge (
                .old_field (cr[31-4*gi -: 4]),
                .new_field (RS_DATA[31-4*gi -: 4]),
                .sel       (field_select_mask[7-gi]),
                .merged    (crm_merged[31-4*gi -: 4])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next-state computation
    always_comb begin
        next_state   = state;
        next_cr      = cr;
        next_fxer    = fxer;
        next_link    = link;
        next_count   = count;
        next_msr     = machine_state_register;
        next_tb      = tb;
        next_tb_div  = tb_div;
        next_pend_rd = pend_rd;
        next_spr_req = '0;
        next_spr_req.num = spr_req.num;
        next_gpr_wr  = '0;
        next_gpr_wr.addr = gpr_wr.addr;
        next_gpr_wr.data = gpr_wr.data;
        next_exc     = '0;
        next_exc.cause  = EXC_NONE;

        // Time base tick from the divider enable
        if (tb_div == `TB_DIV_W'(`TB_DIV - 1)) begin
            next_tb_div = '0;
            next_tb     = tb + 64'h1;
        end else begin
            next_tb_div = tb_div + `TB_DIV_W'(1);
        end

        unique case (state)
            ST_IDLE: begin
                if (take) begin
                    unique case (op)
                        OP_SYSCALL: begin
                            next_exc.valid  = 1'b1;
                            next_exc.cause  = EXC_SYSCALL;
                            next_exc.vector = `VEC_SYSCALL;
                        end
                        OP_MTCRF: begin
                            next_cr = crm_merged;
                        end
                        OP_MCRXR: begin
                            next_cr[31-4*crf -: 4] = fxer[31:28];
                            next_fxer[31:28] = 4'h0;
                        end
                        OP_MFCR: begin
                            next_gpr_wr.we   = 1'b1;
                            next_gpr_wr.addr = rd_rs;
                            next_gpr_wr.data = cr;
                        end
                        OP_MFMSR, OP_MTMSR: begin
                            if (!SUPERVISOR) begin
                                next_exc.valid  = 1'b1;
                                next_exc.cause  = EXC_PRIVILEGED;
                                next_exc.vector = `VEC_PROGRAM;
                            end else if (op == OP_MTMSR) begin
                                next_msr = RS_DATA;
                            end else begin
                                next_gpr_wr.we   = 1'b1;
                                next_gpr_wr.addr = rd_rs;
                                next_gpr_wr.data = machine_state_register;
                            end
                        end
                        OP_MTSPR: begin
                            if (!acc.known || (SUPERVISOR && !acc.wr_sup))
                            begin
                                next_exc.valid  = 1'b1;
                                next_exc.cause  = EXC_ILLEGAL;
                                next_exc.vector = `VEC_PROGRAM;
                            end else if (!SUPERVISOR && !acc.wr_user) begin
                                next_exc.valid  = 1'b1;
                                next_exc.cause  = EXC_PRIVILEGED;
                                next_exc.vector = `VEC_PROGRAM;
                            end else begin
                                unique case (spr_num)
                                    `SPR_FXER:     next_fxer  = RS_DATA;
                                    `SPR_LINK:     next_link  = RS_DATA;
                                    `SPR_COUNT:    next_count = RS_DATA;
                                    `SPR_TB_WR_LO:
                                        next_tb[31:0] = RS_DATA;
                                    `SPR_TB_WR_HI:
                                        next_tb[63:32] = RS_DATA;
                                    default: begin
                                        next_spr_req.wr    = 1'b1;
                                        next_spr_req.num   = spr_num;
                                        next_spr_req.wdata = RS_DATA;
                                    end
                                endcase
                            end
                        end
                        OP_MFSPR, OP_MFTB: begin
                            if (!acc.known || (SUPERVISOR && !acc.rd_sup)
                                || (op == OP_MFTB
                                    && spr_num != `SPR_TB_RD_LO
                                    && spr_num != `SPR_TB_RD_HI)) begin
                                next_exc.valid  = 1'b1;
                                next_exc.cause  = EXC_ILLEGAL;
                                next_exc.vector = `VEC_PROGRAM;
                            end else if (!SUPERVISOR && !acc.rd_user) begin
                                next_exc.valid  = 1'b1;
                                next_exc.cause  = EXC_PRIVILEGED;
                                next_exc.vector = `VEC_PROGRAM;
                            end else begin
                                next_gpr_wr.addr = rd_rs;
                                unique case (spr_num)
                                    `SPR_FXER: begin
                                        next_gpr_wr.we   = 1'b1;
                                        next_gpr_wr.data = fxer;
                                    end
                                    `SPR_LINK: begin
                                        next_gpr_wr.we   = 1'b1;
                                        next_gpr_wr.data = link;
                                    end
                                    `SPR_COUNT: begin
                                        next_gpr_wr.we   = 1'b1;
                                        next_gpr_wr.data = count;
                                    end
                                    `SPR_TB_RD_LO: begin
                                        next_gpr_wr.we   = 1'b1;
                                        next_gpr_wr.data = tb[31:0];
                                    end
                                    `SPR_TB_RD_HI: begin
                                        next_gpr_wr.we   = 1'b1;
                                        next_gpr_wr.data = tb[63:32];
                                    end
                                    default: begin
                                        next_spr_req.rd  = 1'b1;
                                        next_spr_req.num = spr_num;
                                        next_pend_rd     = rd_rs;
                                        next_state       = ST_EXT_READ;
                                    end
                                endcase
                            end
                        end
                        OP_ILLEGAL: begin
                            next_exc.valid  = 1'b1;
                            next_exc.cause  = EXC_ILLEGAL;
                            next_exc.vector = `VEC_PROGRAM;
                        end
                        default: ;
                    endcase
                end
            end
            ST_EXT_READ: begin
                // Outside register answers during the request cycle
                next_gpr_wr.we   = 1'b1;
                next_gpr_wr.addr = pend_rd;
                next_gpr_wr.data = SPR_RDATA;
                next_state       = ST_IDLE;
            end
        endcase
        next_ready = (next_state == ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            state   <= ST_IDLE;
            cr      <= `CR_RESET;
            fxer    <= `FXER_RESET;
            link    <= `LINK_RESET;
            count   <= `COUNT_RESET;
            machine_state_register     <= `MSR_RESET;
            tb      <= `TB_RESET;
            tb_div  <= '0;
            pend_rd <= '0;
            ready   <= 1'b0;
            spr_req <= '0;
            gpr_wr  <= '0;
            exc     <= '0;
        end else begin
            state   <= next_state;
            cr      <= next_cr;
            fxer    <= next_fxer;
            link    <= next_link;
            count   <= next_count;
            machine_state_register     <= next_msr;
            tb      <= next_tb;
            tb_div  <= next_tb_div;
            pend_rd <= next_pend_rd;
            ready   <= next_ready;
            spr_req <= next_spr_req;
            gpr_wr  <= next_gpr_wr;
            exc     <= next_exc;
        end
    end

    // Outputs straight from flip-flops
    assign READY     = ready;
    assign SPR_REQ   = spr_req;
    assign GPR_WR    = gpr_wr;
    assign EXC       = exc;
    assign CR_VALUE  = cr;
    assign MSR_VALUE = machine_state_register;

endmodule
`default_nettype wire

// ### test/pctl_decoder_checker.sv
// Purpose: port-level assertions for the processor control decoder
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every pctl_decoder instance
`timescale 1ns/1ps
`default_nettype none
`include "pctl_cfg.svh"
module pctl_decoder_checker import pctl_pkg::*; (
    // Clock and reset
    input wire logic              CLK_SYS,
    input wire logic              RST_N,
    // Instruction side
    input wire logic              INSTR_VALID,
    input wire logic [31:0]       INSTR,
    input wire logic [31:0]       RS_DATA,
    input wire logic              SUPERVISOR,
    input wire logic              READY,
    // Outside registers and results
    input wire pctl_pkg::spr_req_s SPR_REQ,
    input wire logic [31:0]       SPR_RDATA,
    input wire pctl_pkg::gpr_wr_s GPR_WR,
    input wire pctl_pkg::exc_s    EXC,
    input wire logic [31:0]       CR_VALUE
);
    // Decode of the presented word
    wire         tk = INSTR_VALID && READY;
    wire [9:0]   sn = {INSTR[15:11], INSTR[20:16]};
    wire [9:0]   xo = INSTR[10:1];
    wire         xt = tk && INSTR[31:26] == `OPC_EXTENDED;
    wire         mt = xt && xo == `XO_MTSPR && !SUPERVISOR;
    logic [31:0] msk;
    // Field mask expanded to bits
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            msk[31-4*i -: 4] = {4{INSTR[19-i]}};
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    sequence s_fetch;
        SPR_REQ.rd && !READY;
    endsequence
    sequence s_land;
        GPR_WR.we && READY && GPR_WR.data == $past(SPR_RDATA);
    endsequence
    AST_SC_VEC: assert property (tk && INSTR == 32'h4400_0002 |=>
        EXC.valid && EXC.cause == EXC_SYSCALL && EXC.vector == `VEC_SYSCALL)
        else $error("system call exception missing");
    AST_CR_MERGE: assert property (xt && xo == `XO_MTCRF |=>
        CR_VALUE == (($past(CR_VALUE) & ~$past(msk))
                     | ($past(RS_DATA) & $past(msk))))
        else $error("condition field move wrong");
    AST_CR_COPY: assert property (xt && xo == `XO_MFCR |=>
        GPR_WR.we && GPR_WR.data == $past(CR_VALUE))
        else $error("condition copy wrong");
    AST_NUM_SWAP: assert property (SPR_REQ.wr || SPR_REQ.rd |->
        SPR_REQ.num == $past(sn)) else $error("register number not swapped");
    AST_USER_NO_WR: assert property (SPR_REQ.wr |-> $past(SUPERVISOR))
        else $error("user write reached outside register");
    AST_CFG_PRIV: assert property (mt && (sn == `SPR_HWCFG_A ||
        sn == `SPR_HWCFG_B || sn == `SPR_L2CTRL) |=> EXC.valid &&
        EXC.cause == EXC_PRIVILEGED && EXC.vector == `VEC_PROGRAM)
        else $error("user config write not refused");
    AST_UPERF_RD: assert property (xt && xo == `XO_MFSPR &&
        sn >= `SPR_UPERF_FIRST && sn <= `SPR_UPERF_LAST |=> s_fetch ##1 s_land)
        else $error("user counter read sequence wrong");
    AST_TB_WR_PRIV: assert property (mt && (sn == `SPR_TB_WR_LO ||
        sn == `SPR_TB_WR_HI) |=> EXC.valid && EXC.cause == EXC_PRIVILEGED)
        else $error("user time base write not refused");
    AST_TB_RD_USER: assert property (xt && !SUPERVISOR &&
        (xo == `XO_MFSPR || xo == `XO_MFTB) && (sn == `SPR_TB_RD_LO ||
        sn == `SPR_TB_RD_HI) |=> GPR_WR.we && !EXC.valid)
        else $error("user time base read refused");
endmodule
bind pctl_decoder pctl_decoder_checker i_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .RS_DATA(RS_DATA),
    .SUPERVISOR(SUPERVISOR), .READY(READY), .SPR_REQ(SPR_REQ),
    .SPR_RDATA(SPR_RDATA), .GPR_WR(GPR_WR), .EXC(EXC), .CR_VALUE(CR_VALUE));
`default_nettype wire

// ### test/processor_control_spr_decode_bench.sv
// Purpose: self-checking bench for the processor control decoder
// Assumes: far side answers outside reads in the request cycle
// Notes:   expectations come from a small register model
`timescale 1ns/1ps
`default_nettype none
`include "pctl_cfg.svh"
`define CHK(n, e, a) begin \
    cmp_count++; \
    if ((a) !== (e)) begin \
        $display("unexpected %s exp %h got %h", n, (e), (a)); \
        n_mismatch++; \
    end \
end
module processor_control_spr_decode_bench import pctl_pkg::*;;
    logic        clk_sys, rst_n, instr_valid, supervisor, ready;
    logic [31:0] instr, rs_data, spr_rdata, cr_value, msr_value, cr, v;
    logic [7:0]  m;
    logic [9:0]  un[3] = '{`SPR_LINK, `SPR_COUNT, `SPR_FXER};
    logic [9:0]  hw[3] = '{`SPR_HWCFG_A, `SPR_HWCFG_B, `SPR_L2CTRL};
    integer      seed = 32'h0595;
    int          n_mismatch, cmp_count, cyc;
    spr_req_s    spr_req, rq;
    gpr_wr_s     gpr_wr, gw;
    exc_s        exc, ex;
    pctl_decoder i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n),
        .INSTR_VALID(instr_valid), .INSTR(instr), .RS_DATA(rs_data),
        .SUPERVISOR(supervisor), .READY(ready), .SPR_REQ(spr_req),
        .SPR_RDATA(spr_rdata), .GPR_WR(gpr_wr), .EXC(exc),
        .CR_VALUE(cr_value), .MSR_VALUE(msr_value));
    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 1000) begin
            n_mismatch++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Present one word, capture the answer, serve an outside read
    task automatic run(input logic [31:0] i, input logic [31:0] rs,
                       input logic s);
        @(negedge clk_sys);
        instr_valid = 1'b1;
        instr = i;
        rs_data = rs;
        supervisor = s;
        @(negedge clk_sys);
        instr_valid = 1'b0;
        rq = spr_req;
        gw = gpr_wr;
        ex = exc;
        if (spr_req.rd === 1'b1) begin
            spr_rdata = v;
            @(negedge clk_sys);
            gw = gpr_wr;
            spr_rdata = ~v;
        end
    endtask
    // Compare exception and write-back against expectation
    task automatic ck(input exc_cause_e c, input logic we,
                      input logic [31:0] d);
        logic [31:0] ev;
        ev = c == EXC_NONE ? 32'h0 :
             c == EXC_SYSCALL ? `VEC_SYSCALL : `VEC_PROGRAM;
        `CHK("exc.valid", c != EXC_NONE, ex.valid)
        `CHK("exc.vector", ev, ex.vector)
        if (c != EXC_NONE) `CHK("exc.cause", c, ex.cause)
        `CHK("gpr.we", we, gw.we)
        if (we) `CHK("gpr.data", d, gw.data)
        if (we) `CHK("gpr.addr", 5'h03, gw.addr)
    endtask
    function automatic logic [31:0] sp(input logic [9:0] xo,
                                       input logic [9:0] n);
        return {6'h1F, 5'h03, n[4:0], n[9:5], xo, 1'b0};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {instr_valid, instr, rs_data, supervisor, spr_rdata, v} = '0;
        rst_n = 1'b0;
        cr = '0;
        repeat (9) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        `CHK("ready", 1'b1, ready)
        `CHK("cr", cr, cr_value)
        run(32'h4400_0002, $random(seed), 1'b0);
        ck(EXC_SYSCALL, 1'b0, 0);
        for (int k = 0; k < 6; k++) begin
            v = $random(seed);
            m = k == 0 ? 8'hFF : v[15:8];
            run({6'h1F, 5'h04, 1'b0, m, 1'b0, `XO_MTCRF, 1'b0}, v, k[0]);
            for (int f = 0; f < 8; f++)
                if (m[7-f]) cr[31-4*f -: 4] = v[31-4*f -: 4];
            `CHK("cr", cr, cr_value)
        end
        run({6'h1F, 5'h03, 10'h000, `XO_MFCR, 1'b0}, 0, 1'b0);
        ck(EXC_NONE, 1'b1, cr);
        $display("test condition moves done");
        foreach (un[j]) begin
            v = $random(seed);
            run(sp(`XO_MTSPR, un[j]), v, 1'b0);
            ck(EXC_NONE, 1'b0, 0);
            run(sp(`XO_MFSPR, un[j]), 0, 1'b0);
            ck(EXC_NONE, 1'b1, v);
        end
        run({6'h1F, 3'h2, 12'h000, `XO_MCRXR, 1'b0}, 0, 1'b0);
        cr[23:20] = v[31:28];
        `CHK("cr", cr, cr_value)
        run(sp(`XO_MFSPR, `SPR_FXER), 0, 1'b0);
        ck(EXC_NONE, 1'b1, {4'h0, v[27:0]});
        $display("test user registers done");
        foreach (hw[j]) begin
            v = $random(seed);
            run(sp(`XO_MTSPR, hw[j]), v, 1'b0);
            ck(EXC_PRIVILEGED, 1'b0, 0);
            `CHK("spr.wr", 1'b0, rq.wr)
            run(sp(`XO_MTSPR, hw[j]), v, 1'b1);
            `CHK("spr.wr", 1'b1, rq.wr)
            `CHK("spr.num", hw[j], rq.num)
            `CHK("spr.wdata", v, rq.wdata)
            run(sp(`XO_MFSPR, hw[j]), 0, 1'b1);
            ck(EXC_NONE, 1'b1, v);
        end
        for (int n = `SPR_UPERF_FIRST; n <= `SPR_UPERF_LAST; n++) begin
            v = $random(seed);
            run(sp(`XO_MFSPR, n[9:0]), 0, n[0]);
            `CHK("spr.rd", 1'b1, rq.rd)
            ck(EXC_NONE, 1'b1, v);
            run(sp(`XO_MTSPR, n[9:0]), v, n[0]);
            ck(n[0] ? EXC_ILLEGAL : EXC_PRIVILEGED, 1'b0, 0);
        end
        $display("test outside registers done");
        v = $random(seed);
        run(sp(`XO_MTSPR, `SPR_TB_WR_HI), v, 1'b0);
        ck(EXC_PRIVILEGED, 1'b0, 0);
        run(sp(`XO_MTSPR, `SPR_TB_WR_HI), v, 1'b1);
        run(sp(`XO_MTSPR, `SPR_TB_WR_LO), 0, 1'b1);
        ck(EXC_NONE, 1'b0, 0);
        run(sp(`XO_MFSPR, `SPR_TB_RD_HI), 0, 1'b0);
        ck(EXC_NONE, 1'b1, v);
        run(sp(`XO_MFTB, `SPR_TB_RD_HI), 0, 1'b0);
        ck(EXC_NONE, 1'b1, v);
        run(sp(`XO_MFTB, `SPR_FXER), 0, 1'b0);
        ck(EXC_ILLEGAL, 1'b0, 0);
        run({6'h1F, 5'h03, 10'h000, `XO_MTMSR, 1'b0}, v, 1'b1);
        `CHK("msr", v, msr_value)
        run({6'h1F, 5'h03, 10'h000, `XO_MFMSR, 1'b0}, 0, 1'b0);
        ck(EXC_PRIVILEGED, 1'b0, 0);
        run({6'h1F, 5'h03, 10'h000, `XO_MFMSR, 1'b0}, 0, 1'b1);
        ck(EXC_NONE, 1'b1, v);
        $display("test time base done");
        conclude();
    end
endmodule
`default_nettype wire
